// [cpfc_defs.vh]
`ifndef CPFC_DEFS_VH
`define CPFC_DEFS_VH
// Pin function codes
`define CPFC_FN_DEFAULT 4'h0
`define CPFC_FN_USER_IN 4'h1
`define CPFC_FN_USER_IO 4'h2
`define CPFC_FN_POT_PWR 4'h3
`define CPFC_FN_SERIAL 4'h4
`define CPFC_FN_PULSE_IN 4'h5
`define CPFC_FN_ENC_IN 4'h6
`define CPFC_FN_KILL 4'h7
`define CPFC_FN_LIM_FWD 4'h8
`define CPFC_FN_LIM_REV 4'h9
// Control modes
`define CPFC_MODE_SERIAL 3'h0
`define CPFC_MODE_STEPDIR 3'h1
`define CPFC_MODE_RC_SPD 3'h2
`define CPFC_MODE_RC_POS 3'h3
`define CPFC_MODE_AN_SPD 3'h4
`define CPFC_MODE_AN_POS 3'h5
`define CPFC_MODE_ENC_SPD 3'h6
`define CPFC_MODE_ENC_POS 3'h7
// Soft error responses
`define CPFC_SER_DEENERGIZE 2'h0
`define CPFC_SER_HALT_HOLD 2'h1
`define CPFC_SER_DECEL_HOLD 2'h2
`define CPFC_SER_GOTO_POS 2'h3
// Pin indices
`define CPFC_PIN_SCL 0
`define CPFC_PIN_SDA 1
`define CPFC_PIN_TX 2
`define CPFC_PIN_RX 3
`define CPFC_PIN_PULSE 4
// Learn sequence states
`define CPFC_LS_IDLE 2'h0
`define CPFC_LS_COPY 2'h1
`define CPFC_LS_CLEAR 2'h2
`endif

// [cpfc_sync.v]
`timescale 1ns/1ps
`include "cpfc_defs.vh"
module cpfc_sync #(
    parameter WIDTH = 5
) (
    input wire sys_clk,
    input wire rst,
    input wire clkEn,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    // Two flops; only the second is visible outside
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else if (clkEn) begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end
    assign syncOut = stage2_reg;
endmodule // cpfc_sync

// [cpfc_pin_config.v]
// Summary of operation
// RULE1 - Position modes: at normal start with uncertain flag, copy target to current, clear flag.
// RULE2 - Decelerate-to-hold or go-to-position soft errors leave the uncertain flag alone.
// RULE3 - Default pins take roles from control mode; pulse pin always pulse input.
// RULE4 - TX and RX always pulled up; pulse pin always pulled down.
// RULE5 - Default-function pins ignore stored pull-up, polarity and analog options but keep them.
// RULE6 - User-input pins sampled digitally and optionally analog; readable as variables.
// RULE7 - User I/O equals user input, only on clock, data, TX, RX.
// RULE8 - Potentiometer power only on clock pin, driven high continuously.
// RULE9 - RX serial may stand alone; TX transmits only in answer to RX commands.
// RULE10 - I2C needs clock and data pins both serial; never one alone.
// RULE11 - Pulse width measurement always runs on the pulse pin.
// RULE12 - Quadrature decoding on TX and RX always runs.
// RULE13 - Kill pin active on high level if active-high set, else on low.
// RULE14 - Kill error bit set while any kill pin active, cleared when all inactive.
// RULE15 - Kill error is a soft error handled by the configured response.
// RULE16 - Forward and reverse limit pins block their direction, polarity by active-high.
// RULE17 - Limit active while moving that way: stop stepping at once, set uncertain flag.
// RULE18 - Configurable pull-up exists only on clock and data pins.
// RULE19 - Pull-up option ignored at default function or functions without pull-ups.
// RULE20 - Halt-and-hold stops at once, keeps coils on, sets uncertain; de-energize also sets it.
// RULE21 - All pin inputs synchronised before polarity, kill or limit evaluation.
`timescale 1ns/1ps
`include "cpfc_defs.vh"
module cpfc_pin_config #(
    parameter POS_WIDTH = 32,
    parameter PULSE_WIDTH = 16
) (
    input wire sys_clk,
    input wire rst,
    input wire clkEn,
    input wire [2:0] controlMode,
    input wire [19:0] pinFunction,
    input wire [4:0] pullUpOpt,
    input wire [4:0] activeHighOpt,
    input wire [4:0] analogOpt,
    input wire [1:0] softErrResponse,
    input wire [4:0] pinLevel,
    input wire normalStart,
    input wire softErrorEntry,
    input wire otherSoftError,
    input wire uncertainSet,
    input wire moveFwd,
    input wire moveRev,
    input wire [POS_WIDTH-1:0] targetPosition,
    input wire [POS_WIDTH-1:0] currentPositionIn,
    input wire uartTxData,
    input wire uartTxBusy,
    input wire rxCmdPending,
    input wire i2cSclOut,
    input wire i2cSdaOut,
    output reg [POS_WIDTH-1:0] currentPositionOut,
    output reg currentPositionLoad,
    output reg positionUncertain,
    output reg killSwitchError,
    output reg softError,
    output reg stepHaltNow,
    output reg decelToHold,
    output reg gotoPosition,
    output reg coilEnable,
    output reg blockFwd,
    output reg blockRev,
    output reg [4:0] pullUpEn,
    output reg [4:0] pullDownEn,
    output reg [4:0] analogEn,
    output reg [4:0] userInputState,
    output reg [4:0] pinOutValue,
    output reg [4:0] pinOutEnN,
    output reg serialRxEn,
    output reg serialTxEn,
    output reg i2cEn,
    output reg [PULSE_WIDTH-1:0] pulseWidth,
    output reg pulseWidthValid,
    output reg [1:0] encoderStep
);
    wire [4:0] pinSync;
    reg [3:0] effFn [0:4];
    reg [4:0] killActive;
    reg [4:0] limFwdActive;
    reg [4:0] limRevActive;
    reg [4:0] userPins;
    reg [1:0] learnState_reg;
    reg [1:0] learnState_next;
    reg [POS_WIDTH-1:0] learnTarget_reg;
    reg pulsePrev_reg;
    reg [PULSE_WIDTH-1:0] pulseCount_reg;
    reg [1:0] encPrev_reg;
    reg txGrant_reg;
    integer i;
    integer j;
    integer k;

    cpfc_sync #(
        .WIDTH(5)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .asyncIn(pinLevel),
        .syncOut(pinSync)
    ); // RULE21

    function isPositionMode;
        input [2:0] mode;
        begin
            isPositionMode = (mode == `CPFC_MODE_RC_POS) || (mode == `CPFC_MODE_AN_POS) ||
                (mode == `CPFC_MODE_ENC_POS);
        end
    endfunction

    function isAnalogMode;
        input [2:0] mode;
        begin
            isAnalogMode = (mode == `CPFC_MODE_AN_POS) || (mode == `CPFC_MODE_AN_SPD);
        end
    endfunction

    function isEncoderMode;
        input [2:0] mode;
        begin
            isEncoderMode = (mode == `CPFC_MODE_ENC_POS) || (mode == `CPFC_MODE_ENC_SPD);
        end
    endfunction

    // Unsupported function on a pin falls back to user input
    function [3:0] legalFn;
        input [2:0] pin;
        input [3:0] fn;
        begin
            legalFn = fn;
            case (fn)
                `CPFC_FN_USER_IO: if (pin == `CPFC_PIN_PULSE) legalFn = `CPFC_FN_USER_IN; // RULE7
                `CPFC_FN_POT_PWR: if (pin != `CPFC_PIN_SCL) legalFn = `CPFC_FN_USER_IN; // RULE8
                `CPFC_FN_SERIAL: if (pin == `CPFC_PIN_PULSE) legalFn = `CPFC_FN_USER_IN;
                `CPFC_FN_PULSE_IN: if (pin != `CPFC_PIN_PULSE) legalFn = `CPFC_FN_USER_IN;
                `CPFC_FN_ENC_IN: if (pin != `CPFC_PIN_TX && pin != `CPFC_PIN_RX) legalFn = `CPFC_FN_USER_IN;
                `CPFC_FN_DEFAULT, `CPFC_FN_USER_IN, `CPFC_FN_KILL, `CPFC_FN_LIM_FWD, `CPFC_FN_LIM_REV: legalFn = fn;
                default: legalFn = `CPFC_FN_USER_IN;
            endcase
        end
    endfunction

    // Resolve default function from control mode
    always @* begin
        for (j = 0; j < 5; j = j + 1) begin
            effFn[j] = legalFn(j[2:0], pinFunction[j*4 +: 4]);
        end
        if (effFn[`CPFC_PIN_SCL] == `CPFC_FN_DEFAULT) begin
            effFn[`CPFC_PIN_SCL] = isAnalogMode(controlMode) ? `CPFC_FN_POT_PWR : `CPFC_FN_SERIAL; // RULE3
        end
        if (effFn[`CPFC_PIN_SDA] == `CPFC_FN_DEFAULT) begin
            effFn[`CPFC_PIN_SDA] = isAnalogMode(controlMode) ? `CPFC_FN_USER_IN : `CPFC_FN_SERIAL; // RULE3
        end
        if (effFn[`CPFC_PIN_TX] == `CPFC_FN_DEFAULT) begin
            effFn[`CPFC_PIN_TX] = isEncoderMode(controlMode) ? `CPFC_FN_ENC_IN : `CPFC_FN_SERIAL; // RULE3
        end
        if (effFn[`CPFC_PIN_RX] == `CPFC_FN_DEFAULT) begin
            effFn[`CPFC_PIN_RX] = isEncoderMode(controlMode) ? `CPFC_FN_ENC_IN : `CPFC_FN_SERIAL; // RULE3
        end
        if (effFn[`CPFC_PIN_PULSE] == `CPFC_FN_DEFAULT) begin
            effFn[`CPFC_PIN_PULSE] = `CPFC_FN_PULSE_IN; // RULE3
        end
    end

    // Pin condition decode on synchronised levels
    always @* begin
        for (i = 0; i < 5; i = i + 1) begin
            // Polarity only honoured on explicitly assigned pins
            killActive[i] = (effFn[i] == `CPFC_FN_KILL) &&
                (activeHighOpt[i] ? pinSync[i] : ~pinSync[i]); // RULE13 RULE5
            limFwdActive[i] = (effFn[i] == `CPFC_FN_LIM_FWD) &&
                (activeHighOpt[i] ? pinSync[i] : ~pinSync[i]); // RULE16
            limRevActive[i] = (effFn[i] == `CPFC_FN_LIM_REV) &&
                (activeHighOpt[i] ? pinSync[i] : ~pinSync[i]); // RULE16
            // User input, user I/O, encoder and pulse input all read alike
            userPins[i] = (effFn[i] == `CPFC_FN_USER_IN) || (effFn[i] == `CPFC_FN_USER_IO) ||
                (effFn[i] == `CPFC_FN_ENC_IN) || (effFn[i] == `CPFC_FN_PULSE_IN); // RULE7 RULE11 RULE12
        end
    end

    // Learn position sequence
    always @* begin
        learnState_next = learnState_reg;
        case (learnState_reg)
            `CPFC_LS_IDLE: if (normalStart && positionUncertain && isPositionMode(controlMode))
                learnState_next = `CPFC_LS_COPY; // RULE1
            `CPFC_LS_COPY: learnState_next = `CPFC_LS_CLEAR;
            `CPFC_LS_CLEAR: learnState_next = `CPFC_LS_IDLE;
            default: learnState_next = `CPFC_LS_IDLE;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            learnState_reg <= `CPFC_LS_IDLE;
            learnTarget_reg <= {POS_WIDTH{1'b0}};
            currentPositionOut <= {POS_WIDTH{1'b0}};
            currentPositionLoad <= 1'b0;
            positionUncertain <= 1'b1;
            killSwitchError <= 1'b0;
            softError <= 1'b0;
            stepHaltNow <= 1'b0;
            decelToHold <= 1'b0;
            gotoPosition <= 1'b0;
            coilEnable <= 1'b1;
            blockFwd <= 1'b0;
            blockRev <= 1'b0;
        end else if (clkEn) begin
            learnState_reg <= learnState_next;
            currentPositionLoad <= 1'b0;
            decelToHold <= 1'b0;
            gotoPosition <= 1'b0;
            stepHaltNow <= 1'b0;
            if (learnState_reg == `CPFC_LS_IDLE && learnState_next == `CPFC_LS_COPY) begin
                learnTarget_reg <= targetPosition;
            end
            if (learnState_reg == `CPFC_LS_COPY) begin
                currentPositionOut <= learnTarget_reg; // RULE1
                currentPositionLoad <= 1'b1;
            end else begin
                currentPositionOut <= currentPositionIn;
            end
            killSwitchError <= |killActive; // RULE14
            softError <= (|killActive) | otherSoftError; // RULE15
            blockFwd <= |limFwdActive; // RULE16
            blockRev <= |limRevActive; // RULE16
            coilEnable <= 1'b1;
            if (softErrorEntry) begin
                case (softErrResponse) // RULE15
                    `CPFC_SER_DEENERGIZE: coilEnable <= 1'b0; // RULE20
                    `CPFC_SER_HALT_HOLD: stepHaltNow <= 1'b1; // RULE20
                    `CPFC_SER_DECEL_HOLD: decelToHold <= 1'b1; // RULE2
                    `CPFC_SER_GOTO_POS: gotoPosition <= 1'b1; // RULE2
                    default: decelToHold <= 1'b1;
                endcase
            end else if (softError && softErrResponse == `CPFC_SER_DEENERGIZE) begin
                coilEnable <= 1'b0;
            end
            if (((|limFwdActive) && moveFwd) || ((|limRevActive) && moveRev)) begin
                stepHaltNow <= 1'b1; // RULE17
            end
            // Setting wins over the learn clear
            if ((((|limFwdActive) && moveFwd) || ((|limRevActive) && moveRev)) || uncertainSet ||
                (softErrorEntry && (softErrResponse == `CPFC_SER_DEENERGIZE ||
                softErrResponse == `CPFC_SER_HALT_HOLD))) begin
                positionUncertain <= 1'b1; // RULE17 RULE20 RULE2
            end else if (learnState_reg == `CPFC_LS_CLEAR) begin
                positionUncertain <= 1'b0; // RULE1
            end
        end
    end

    // Pin electrical configuration
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pullUpEn <= 5'h0C;
            pullDownEn <= 5'h10;
            analogEn <= 5'h00;
            pinOutValue <= 5'h00;
            pinOutEnN <= 5'h1F;
            serialRxEn <= 1'b0;
            serialTxEn <= 1'b0;
            i2cEn <= 1'b0;
            userInputState <= 5'h00;
            txGrant_reg <= 1'b0;
        end else if (clkEn) begin
            for (k = 0; k < 2; k = k + 1) begin
                if (pinFunction[k*4 +: 4] == `CPFC_FN_DEFAULT) begin
                    pullUpEn[k] <= (effFn[k] == `CPFC_FN_SERIAL); // RULE5 RULE19
                    analogEn[k] <= (k == `CPFC_PIN_SDA) && isAnalogMode(controlMode); // RULE5 RULE3
                end else begin
                    pullUpEn[k] <= pullUpOpt[k] && (effFn[k] != `CPFC_FN_POT_PWR); // RULE18 RULE19
                    analogEn[k] <= analogOpt[k] && userPins[k]; // RULE6
                end
            end
            pullUpEn[`CPFC_PIN_TX] <= 1'b1; // RULE4
            pullUpEn[`CPFC_PIN_RX] <= 1'b1; // RULE4
            pullUpEn[`CPFC_PIN_PULSE] <= 1'b0; // RULE18
            pullDownEn <= 5'h10; // RULE4
            for (k = 2; k < 4; k = k + 1) begin
                analogEn[k] <= (pinFunction[k*4 +: 4] != `CPFC_FN_DEFAULT) && analogOpt[k] && userPins[k]; // RULE5 RULE6
            end
            analogEn[`CPFC_PIN_PULSE] <= 1'b0;
            userInputState <= pinSync & userPins; // RULE6
            i2cEn <= (effFn[`CPFC_PIN_SCL] == `CPFC_FN_SERIAL) && (effFn[`CPFC_PIN_SDA] == `CPFC_FN_SERIAL); // RULE10
            serialRxEn <= (effFn[`CPFC_PIN_RX] == `CPFC_FN_SERIAL); // RULE9
            serialTxEn <= (effFn[`CPFC_PIN_TX] == `CPFC_FN_SERIAL);
            // Transmit only while answering a received command
            txGrant_reg <= (effFn[`CPFC_PIN_RX] == `CPFC_FN_SERIAL) && (effFn[`CPFC_PIN_TX] == `CPFC_FN_SERIAL) &&
                (rxCmdPending || (txGrant_reg && uartTxBusy)); // RULE9
            pinOutEnN <= 5'h1F;
            pinOutValue <= 5'h00;
            if (effFn[`CPFC_PIN_SCL] == `CPFC_FN_POT_PWR) begin
                pinOutValue[`CPFC_PIN_SCL] <= 1'b1; // RULE8
                pinOutEnN[`CPFC_PIN_SCL] <= 1'b0; // RULE8
            end else if (i2cEn && !i2cSclOut) begin
                pinOutEnN[`CPFC_PIN_SCL] <= 1'b0; // RULE10
            end
            if (i2cEn && !i2cSdaOut) begin
                pinOutEnN[`CPFC_PIN_SDA] <= 1'b0; // RULE10
            end
            if (txGrant_reg) begin
                pinOutValue[`CPFC_PIN_TX] <= uartTxData; // RULE9
                pinOutEnN[`CPFC_PIN_TX] <= 1'b0;
            end
            // Pulse pin bit stays released: never an output
        end
    end

    // Always-on pulse width and quadrature front ends
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pulsePrev_reg <= 1'b0;
            pulseCount_reg <= {PULSE_WIDTH{1'b0}};
            pulseWidth <= {PULSE_WIDTH{1'b0}};
            pulseWidthValid <= 1'b0;
            encPrev_reg <= 2'h0;
            encoderStep <= 2'h0;
        end else if (clkEn) begin
            pulsePrev_reg <= pinSync[`CPFC_PIN_PULSE];
            pulseWidthValid <= 1'b0;
            if (pinSync[`CPFC_PIN_PULSE]) begin
                if (!pulsePrev_reg) begin
                    pulseCount_reg <= {{(PULSE_WIDTH-1){1'b0}}, 1'b1}; // RULE11
                end else if (~&pulseCount_reg) begin
                    pulseCount_reg <= pulseCount_reg + {{(PULSE_WIDTH-1){1'b0}}, 1'b1};
                end
            end else if (pulsePrev_reg) begin
                pulseWidth <= pulseCount_reg; // RULE11
                pulseWidthValid <= 1'b1;
            end
            encPrev_reg <= {pinSync[`CPFC_PIN_RX], pinSync[`CPFC_PIN_TX]};
            // Bit0 step, bit1 direction (1 = forward)
            encoderStep <= 2'h0;
            if ({pinSync[`CPFC_PIN_RX], pinSync[`CPFC_PIN_TX]} != encPrev_reg) begin
                encoderStep[0] <= 1'b1; // RULE12
                encoderStep[1] <= pinSync[`CPFC_PIN_TX] ^ encPrev_reg[1];
            end
        end
    end
endmodule // cpfc_pin_config

// [cpfc_pin_checker.sv]
`timescale 1ns/1ps
`include "cpfc_defs.vh"
module cpfc_pin_checker #(
    parameter POS_WIDTH = 32,
    parameter PULSE_WIDTH = 16
) (
    input wire sys_clk,
    input wire rst,
    input wire clkEn,
    input wire [2:0] controlMode,
    input wire [19:0] pinFunction,
    input wire [4:0] activeHighOpt,
    input wire [4:0] pinLevel,
    input wire normalStart,
    input wire uncertainSet,
    input wire moveFwd,
    input wire [POS_WIDTH-1:0] targetPosition,
    input wire rxCmdPending,
    input wire uartTxBusy,
    input wire [POS_WIDTH-1:0] currentPositionOut,
    input wire currentPositionLoad,
    input wire positionUncertain,
    input wire killSwitchError,
    input wire blockFwd,
    input wire [4:0] pullUpEn,
    input wire [4:0] pullDownEn,
    input wire [4:0] pinOutValue,
    input wire [4:0] pinOutEnN,
    input wire i2cEn
);
    logic killAct;
    logic limAct;
    logic [24:0] cfgPrev;
    // Config changes leave stale synchronised levels for two cycles
    wire cfgHeld = cfgPrev == {pinFunction, activeHighOpt};
    always @(posedge sys_clk) cfgPrev <= {pinFunction, activeHighOpt};
    wire posMode = controlMode[0] && controlMode != 3'h1;
    // Raw levels held four cycles cover the two sync stages
    always_comb begin
        killAct = 1'b0;
        limAct = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (pinLevel[i] == activeHighOpt[i]) begin
                killAct |= pinFunction[4*i+:4] == `CPFC_FN_KILL;
                limAct |= pinFunction[4*i+:4] == `CPFC_FN_LIM_FWD;
            end
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence learnReq;
        normalStart && clkEn && posMode && positionUncertain;
    endsequence
    sequence learnRun;
        (clkEn && !uncertainSet && !limAct)[*2];
    endsequence
    AST_LEARN: assert property (learnReq ##1 learnRun |->
        currentPositionLoad && currentPositionOut == $past(targetPosition, 2) ##1 !positionUncertain)
        else $error("learn sequence wrong");
    AST_NO_LEARN: assert property (normalStart && clkEn && !posMode |-> ##2 !currentPositionLoad)
        else $error("learn outside position mode");
    AST_PULL_FIXED: assert property (pullUpEn[3:2] == 2'b11 && !pullUpEn[4] && pullDownEn == 5'h10)
        else $error("fixed pulls wrong");
    AST_PULSE_NO_DRIVE: assert property (pinOutEnN[4])
        else $error("pulse pin driven");
    AST_KILL_SET: assert property ((clkEn && cfgHeld && killAct)[*4] |-> killSwitchError)
        else $error("kill not flagged");
    AST_KILL_CLEAR: assert property ((clkEn && cfgHeld && !killAct)[*4] |-> !killSwitchError)
        else $error("kill not cleared");
    AST_LIMIT: assert property ((clkEn && cfgHeld && limAct && moveFwd)[*4] |-> blockFwd && positionUncertain)
        else $error("limit not obeyed");
    AST_POT_POWER: assert property ((clkEn && pinFunction[3:0] == `CPFC_FN_POT_PWR)[*2] |->
        !pinOutEnN[0] && pinOutValue[0]) else $error("pot power not driven");
    AST_I2C_PAIR: assert property ((clkEn && (pinFunction[3:0] == `CPFC_FN_SERIAL) !=
        (pinFunction[7:4] == `CPFC_FN_SERIAL) && pinFunction[3:0] != 4'h0 && pinFunction[7:4] != 4'h0)[*2]
        |-> !i2cEn) else $error("i2c on single pin");
    AST_TX_REPLY: assert property ((clkEn && !rxCmdPending && !uartTxBusy)[*3] |-> pinOutEnN[2])
        else $error("tx driven without command");
endmodule // cpfc_pin_checker
bind cpfc_pin_config cpfc_pin_checker #(.POS_WIDTH(POS_WIDTH), .PULSE_WIDTH(PULSE_WIDTH)) cpfc_pin_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .controlMode(controlMode), .pinFunction(pinFunction),
    .activeHighOpt(activeHighOpt), .pinLevel(pinLevel), .normalStart(normalStart), .uncertainSet(uncertainSet),
    .moveFwd(moveFwd), .targetPosition(targetPosition), .rxCmdPending(rxCmdPending), .uartTxBusy(uartTxBusy),
    .currentPositionOut(currentPositionOut), .currentPositionLoad(currentPositionLoad),
    .positionUncertain(positionUncertain), .killSwitchError(killSwitchError), .blockFwd(blockFwd),
    .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .pinOutValue(pinOutValue), .pinOutEnN(pinOutEnN), .i2cEn(i2cEn));

// [cpfc_switch_model.sv]
`timescale 1ns/1ps
module cpfc_switch_model (
    input wire [3:0] swOn,
    input wire [3:0] activeHigh,
    input wire rcPulse,
    output wire [4:0] pinLevel
);
    // Closed switch shows its active level, open shows the other
    assign pinLevel = {rcPulse, ~(swOn ^ activeHigh)};
endmodule // cpfc_switch_model

// [tb_control_pin_function_config.sv]
`timescale 1ns/1ps
module tb_control_pin_function_config;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] controlMode = 3'h0;
    logic [19:0] pinFunction = 20'h0;
    logic [4:0] pullUpOpt = 5'h1F;
    logic [4:0] activeHighOpt = 5'h1F;
    logic [1:0] softErrResponse = 2'h0;
    logic normalStart = 1'b0;
    logic softErrorEntry = 1'b0;
    logic uncertainSet = 1'b0;
    logic moveFwd = 1'b0;
    logic [31:0] targetPosition = 32'h0;
    logic rxCmdPending = 1'b0;
    logic clkEn = 1'b1;
    logic txBusy = 1'b0;
    logic i2cOut = 1'b1;
    logic [3:0] swOn = 4'h0;
    logic rcPulse = 1'b0;
    logic an;
    logic [19:0] fnTab[4] = '{20'h00044, 20'h00044, 20'h00013, 20'h00014};
    logic [4:0] puTab[4] = '{5'h0F, 5'h0C, 5'h0E, 5'h0F};
    logic [1:0] gray[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    wire [4:0] pinLevel, pullUpEn, pullDownEn, analogEn, userIn, outVal, outEnN;
    wire [31:0] curPos;
    wire [15:0] pw;
    wire [1:0] encStep;
    wire posLoad, posUnc, killErr, softErr, blockFwd, rxEn, i2cEn, pwValid, halt, coil;
    int compares = 0;
    int fails = 0;
    int encCount = 0;
    always #12.5 sys_clk = ~sys_clk;
    cpfc_switch_model cpfc_switch_model_inst (.swOn(swOn), .activeHigh(activeHighOpt[3:0]), .rcPulse(rcPulse),
        .pinLevel(pinLevel));
    cpfc_pin_config cpfc_pin_config_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .controlMode(controlMode),
        .pinFunction(pinFunction), .pullUpOpt(pullUpOpt), .activeHighOpt(activeHighOpt), .analogOpt(5'h1F),
        .softErrResponse(softErrResponse), .pinLevel(pinLevel), .normalStart(normalStart),
        .softErrorEntry(softErrorEntry), .otherSoftError(1'b0), .uncertainSet(uncertainSet), .moveFwd(moveFwd),
        .moveRev(1'b0), .targetPosition(targetPosition), .currentPositionIn(32'h0), .uartTxData(1'b1),
        .uartTxBusy(txBusy), .rxCmdPending(rxCmdPending), .i2cSclOut(i2cOut), .i2cSdaOut(i2cOut),
        .currentPositionOut(curPos), .currentPositionLoad(posLoad), .positionUncertain(posUnc),
        .killSwitchError(killErr), .softError(softErr), .stepHaltNow(halt), .decelToHold(), .gotoPosition(),
        .coilEnable(coil), .blockFwd(blockFwd), .blockRev(), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
        .analogEn(analogEn), .userInputState(userIn), .pinOutValue(outVal), .pinOutEnN(outEnN),
        .serialRxEn(rxEn), .serialTxEn(), .i2cEn(i2cEn), .pulseWidth(pw), .pulseWidthValid(pwValid),
        .encoderStep(encStep));
    always @(posedge sys_clk) begin
        if (encStep === 2'h3) encCount++;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Leaves the bench at the edge where the copy shows
    task automatic learn;
        normalStart = 1'b1;
        tick(1);
        normalStart = 1'b0;
        tick(1);
    endtask
    task automatic final_report;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        final_report();
    end
    initial begin
        tick(10);
        check("pullUpRst", pullUpEn, 5'h0C);
        check("pullDnRst", pullDownEn, 5'h10);
        check("uncRst", posUnc, 1);
        rst = 1'b0;
        for (int m = 0; m < 8; m++) begin
            controlMode = m[2:0];
            tick(2);
            an = (m == 4 || m == 5);
            check("pullUp", pullUpEn, an ? 5'h0C : 5'h0F);
            check("analog", analogEn, an ? 5'h02 : 5'h00);
            check("i2c", i2cEn, !an);
            check("potDrive", outEnN[0], !an);
            check("rxSerial", rxEn, m < 6);
        end
        controlMode = 3'h7;
        targetPosition = 32'h1234ABCD;
        learn();
        check("load", posLoad, 1);
        check("curPos", curPos, 32'h1234ABCD);
        tick(1);
        check("uncLearn", posUnc, 0);
        controlMode = 3'h6;
        uncertainSet = 1'b1;
        tick(1);
        uncertainSet = 1'b0;
        learn();
        tick(1);
        check("uncSpeed", posUnc, 1);
        controlMode = 3'h7;
        for (int r = 0; r < 4; r++) begin
            learn();
            tick(1);
            softErrResponse = r[1:0];
            softErrorEntry = 1'b1;
            tick(1);
            check("softResp", {halt, coil}, {r == 1, r != 0});
            softErrorEntry = 1'b0;
            tick(3);
            check("uncSoft", posUnc, r < 2);
        end
        controlMode = 3'h0;
        for (int t = 0; t < 4; t++) begin
            pinFunction = fnTab[t];
            pullUpOpt = (t == 1) ? 5'h00 : 5'h1F;
            tick(2);
            check("pullUpFn", pullUpEn, puTab[t]);
            check("i2cPair", i2cEn, t < 2);
        end
        pinFunction = 20'h12221;
        swOn = 4'hA;
        tick(4);
        check("userIn", userIn, 5'h0A);
        check("userAnalog", analogEn, 5'h0F);
        check("userNoDrive", outEnN, 5'h1F);
        pinFunction = 20'h07700;
        for (int p = 0; p < 2; p++) begin
            activeHighOpt = p ? 5'h1F : 5'h00;
            swOn = 4'h0;
            tick(4);
            check("killIdle", killErr, 0);
            swOn = 4'hC;
            tick(4);
            check("killBoth", killErr, 1);
            check("killSoft", softErr, 1);
            swOn = 4'h8;
            tick(4);
            check("killOne", killErr, 1);
            swOn = 4'h0;
            tick(4);
            check("killNone", killErr, 0);
        end
        pinFunction = 20'h08000;
        moveFwd = 1'b1;
        swOn = 4'h8;
        tick(4);
        check("blockFwd", blockFwd, 1);
        check("uncLimit", posUnc, 1);
        moveFwd = 1'b0;
        swOn = 4'h0;
        for (int f = 0; f < 2; f++) begin
            pinFunction = f ? 20'h10000 : 20'h50000;
            rcPulse = 1'b1;
            tick(10);
            rcPulse = 1'b0;
            for (int k = 0; k < 8 && pwValid !== 1'b1; k++) tick(1);
            check("pulseValid", pwValid, 1);
            check("pulseWidth", pw, 10);
        end
        pinFunction = 20'h02200;
        tick(4);
        encCount = 0;
        for (int g = 0; g < 4; g++) begin
            swOn = {gray[g], 2'b00};
            tick(4);
        end
        check("encSteps", encCount, 4);
        pinFunction = 20'h0;
        rxCmdPending = 1'b1;
        txBusy = 1'b1;
        tick(2);
        check("txReply", outEnN[2], 0);
        rxCmdPending = 1'b0;
        tick(3);
        check("txHold", outEnN[2], 0);
        txBusy = 1'b0;
        tick(3);
        check("txQuiet", outEnN[2], 1);
        i2cOut = 1'b0;
        tick(2);
        check("i2cLow", outEnN[1:0], 2'h0);
        clkEn = 1'b0;
        i2cOut = 1'b1;
        tick(2);
        check("freeze", outEnN[1:0], 2'h0);
        clkEn = 1'b1;
        final_report();
    end
endmodule // tb_control_pin_function_config
